/* File: hdl/release_counter.sv */
// delay counter that times the internal reset release
`timescale 1ns/1ps
`default_nettype none

module release_counter #(
   parameter int unsigned COUNT = 16
) (
   input  wire logic clock,
   input  wire logic arst_n,
   input  wire logic restart,
   output var  logic done
);

   localparam int unsigned CW = (COUNT < 2) ? 1 : $clog2(COUNT);

   // -----------------------------------------------------------------
   // elaboration check
   // -----------------------------------------------------------------
   if (COUNT < 1) begin : g_bad_count
      $error("release count must be at least one");
   end

   logic [CW-1:0] count_ff;

   // -----------------------------------------------------------------
   // counting
   // -----------------------------------------------------------------
   // restart clears at once, so a glitching source always costs
   // the full delay again
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         count_ff <= '0;
         done     <= 1'b0;
      end else if (restart) begin
         count_ff <= '0;
         done     <= 1'b0;
      end else if (!done) begin
         if (count_ff == CW'(COUNT - 1)) begin
            done <= 1'b1;
         end else begin
            count_ff <= count_ff + CW'(1);
         end
      end
   end

endmodule

`default_nettype wire

/* File: hdl/reset_boot_capture.sv */
// chip reset sequencer, boot-mode capture and its register slave
//
// Function
// [R1] while the reset pin is low the chip stays in reset and all logic is set to its initial state; the code keeps por_ff and readdata.
// [R2] internal reset is released in step with the clock only after a fixed count of clocks.
// [R3] the board should assert the reset pin and the test reset together for a full reset.
// [R4] a debugger wanting a chip reset alone asserts only the reset pin and leaves test reset off.
// [R5] a power-on reset puts the chip into reset regardless of the reset pin.
// [R6] the reset output pin always shows the present internal reset state.
// [R7] the reset pin pull-up is on by default and its disable bit turns it off.
// [R8] boot select high with flash unsecured boots external, boot select low boots internal.
// [R9] the boot select disable bit turns off the boot select pull-up.
// [R10] boot is internal by default and ext memory mode, boot select and security modify it.
// [R11] the ext memory mode disable bit turns off the ext memory mode pull-up.
// [R12] in this package both strap inputs count as low so boot is always internal.
// [R13] the system clock source is selectable between resonator, crystal and external clock.
// [R14] the map select and security mode bits are loaded from the straps only at reset; software may also write map select when unsecured.
// [R15] a secured flash with external boot requested gives internal boot with both mode bits zero.
// [R16] the release delay counts from the last inactive source and restarts on any reassertion.
`timescale 1ns/1ps
`default_nettype none

module reset_boot_capture
   import reset_boot_pkg::*;
#(
   parameter int unsigned RELEASE = RELEASE_CYCLES,
   parameter bit          TIE_LOW = 1'b1
) (
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        resetPinN,
   input  wire logic        bootSourceSelect,
   input  wire logic        extMemModeSelect,
   input  wire logic        flashSecured,
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output var  logic [31:0] readdata,
   output var  logic        waitrequest,
   output var  logic        resetOutPin,
   output var  logic        resetPullupEn,
   output var  logic        bootSelPullupEn,
   output var  logic        extMemPullupEn,
   output var  logic        mapSelect,
   output var  logic        securityMode,
   output var  logic        extMemMode,
   output var  logic [1:0]  clkSrcSel
);

   // -----------------------------------------------------------------
   // decode helpers
   // -----------------------------------------------------------------
   function automatic logic hit(input logic [3:0] a,
                                input logic [3:0] ofs);
      hit = (a == ofs);
   endfunction

   function automatic logic legalClk(input logic [1:0] v);
      legalClk = (v == CLK_RESONATOR) || (v == CLK_CRYSTAL) ||
                 (v == CLK_EXTERNAL);
   endfunction

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   seq_state_t  state_ff;
   seq_state_t  nxt_state;
   logic        relDone;
   logic        srcActive;
   logic        inReset;
   logic        bootReq;
   logic        extReq;
   logic [2:0]  pud_ff;
   logic        por_ff;
   logic        pinSeen_ff;
   logic        wrAccept;
   logic        wrLow;
   logic [31:0] nxt_readdata;

   // straps read as low in this package whatever the pads show
   assign bootReq   = TIE_LOW ? 1'b0 : bootSourceSelect;  // see [R12]
   assign extReq    = TIE_LOW ? 1'b0 : extMemModeSelect;  // see [R12]
   assign srcActive = !resetPinN;  // see [R1]
   assign inReset   = (state_ff != SEQ_RUN);

   // -----------------------------------------------------------------
   // reset sequencer
   // -----------------------------------------------------------------
   // the pin is taken as synchronous; power-on comes in on arst_n
   release_counter #(
      .COUNT   (RELEASE)
   ) u_release (
      .clock   (clock),
      .arst_n  (arst_n),
      .restart (srcActive || (state_ff != SEQ_COUNT)),  // see [R16]
      .done    (relDone)
   );

   // next state: any source back in force returns to hold
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SEQ_HOLD: begin
            if (!srcActive) begin
               nxt_state = SEQ_COUNT;
            end
         end
         SEQ_COUNT: begin
            if (srcActive) begin
               nxt_state = SEQ_HOLD;  // see [R16]
            end else if (relDone) begin
               nxt_state = SEQ_RUN;  // see [R2]
            end
         end
         SEQ_RUN: begin
            if (srcActive) begin
               nxt_state = SEQ_HOLD;  // see [R1]
            end
         end
         default: begin
            nxt_state = SEQ_HOLD;
         end
      endcase
   end

   // power-on starts in hold, independent of the pin
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= SEQ_HOLD;  // see [R5]
      end else begin
         state_ff <= nxt_state;
      end
   end

   // reset output tracks the state register exactly
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         resetOutPin <= 1'b1;
      end else begin
         resetOutPin <= (nxt_state != SEQ_RUN);  // see [R6]
      end
   end

   // -----------------------------------------------------------------
   // reset cause flags
   // -----------------------------------------------------------------
   // write one clears; a new event in the same cycle wins
   assign wrAccept = write && !waitrequest && !inReset;
   assign wrLow    = wrAccept && byteenable[0];

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         por_ff     <= 1'b1;  // see [R5]
         pinSeen_ff <= 1'b0;
      end else begin
         if (wrLow && hit(address, OFS_STATUS) && writedata[ST_POR]) begin
            por_ff <= 1'b0;
         end
         if (srcActive) begin
            pinSeen_ff <= 1'b1;
         end else if (wrLow && hit(address, OFS_STATUS) &&
                      writedata[ST_PIN]) begin
            pinSeen_ff <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // pull-up disable register
   // -----------------------------------------------------------------
   // cleared for the whole reset so every pad pull-up comes back on
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         pud_ff <= PUD_RESET_VAL;
      end else if (inReset) begin
         pud_ff <= PUD_RESET_VAL;  // see [R1]
      end else if (wrLow && hit(address, OFS_PULLUP)) begin
         pud_ff <= writedata[2:0];
      end
   end

   // pad enables, active high, off once software sets the bit
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         resetPullupEn   <= 1'b1;
         bootSelPullupEn <= 1'b1;
         extMemPullupEn  <= 1'b1;
      end else begin
         resetPullupEn   <= !pud_ff[PUD_RESET];   // see [R7]
         bootSelPullupEn <= !pud_ff[PUD_BOOT];    // see [R9]
         extMemPullupEn  <= !pud_ff[PUD_EXTMEM];  // see [R11]
      end
   end

   // -----------------------------------------------------------------
   // operating mode capture
   // -----------------------------------------------------------------
   // sampled every reset cycle, so the value at release is the one
   // kept; a later change of flash security is not seen until the
   // next reset
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         securityMode <= 1'b0;
         mapSelect    <= 1'b0;
         extMemMode   <= 1'b0;
      end else if (inReset) begin
         securityMode <= !flashSecured;                 // see [R14]
         mapSelect    <= bootReq && !flashSecured;      // see [R8] [R15]
         extMemMode   <= extReq && bootReq && !flashSecured;  // see [R10]
      end else if (wrLow && hit(address, OFS_MODE) && securityMode) begin
         // software may move the map only if unsecured at reset
         mapSelect    <= writedata[MODE_MAP];  // see [R14]
      end
   end

   // -----------------------------------------------------------------
   // clock source select
   // -----------------------------------------------------------------
   // an unlisted code is refused and the old source kept
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         clkSrcSel <= CLK_RESONATOR;
      end else if (inReset) begin
         clkSrcSel <= CLK_RESONATOR;
      end else if (wrLow && hit(address, OFS_CLKSEL) &&
                   legalClk(writedata[1:0])) begin
         clkSrcSel <= writedata[1:0];  // see [R13]
      end
   end

   // -----------------------------------------------------------------
   // avalon slave
   // -----------------------------------------------------------------
   // read mux; unmapped offsets read zero
   always_comb begin
      nxt_readdata = READ_ZERO;
      if (hit(address, OFS_PULLUP)) begin
         nxt_readdata[2:0] = pud_ff;
      end else if (hit(address, OFS_MODE)) begin
         nxt_readdata[MODE_MAP]  = mapSelect;
         nxt_readdata[MODE_SEC]  = securityMode;
         nxt_readdata[MODE_EXTM] = extMemMode;
      end else if (hit(address, OFS_CLKSEL)) begin
         nxt_readdata[1:0] = clkSrcSel;
      end else if (hit(address, OFS_STATUS)) begin
         nxt_readdata[ST_POR]     = por_ff;
         nxt_readdata[ST_PIN]     = pinSeen_ff;
         nxt_readdata[ST_SECURED] = flashSecured;
         nxt_readdata[ST_BOOTREQ] = bootReq;
      end
   end

   // one wait state; the bus stalls for the whole chip reset, which
   // keeps software off registers that are being forced
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         waitrequest <= 1'b1;
         readdata    <= READ_ZERO;
      end else if (inReset || srcActive) begin
         waitrequest <= 1'b1;  // see [R1]
      end else if ((read || write) && waitrequest) begin
         waitrequest <= 1'b0;
         readdata    <= nxt_readdata;
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   logic [7:0] quiet_ff;  // cycles with the pin high, saturating
   logic [7:0] boot_ff;   // cycles since power-on, saturating

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         quiet_ff <= 8'h00;
         boot_ff  <= 8'h00;
      end else begin
         quiet_ff <= srcActive ? 8'h00 :
                     (quiet_ff == 8'hff) ? quiet_ff : quiet_ff + 8'h01;
         boot_ff  <= (boot_ff == 8'hff) ? boot_ff : boot_ff + 8'h01;
      end
   end

   a_pin_holds_reset: assert property ( // see [R1]
      @(posedge clock) disable iff (!arst_n)
      srcActive |=> resetOutPin && waitrequest)
      else $error("reset pin low did not hold the chip in reset");

   a_release_not_early: assert property ( // see [R2] [R16]
      @(posedge clock) disable iff (!arst_n)
      $fell(resetOutPin) |-> (32'(quiet_ff) >= RELEASE))
      else $error("internal reset released before the fixed delay");

   a_release_not_late: assert property ( // see [R2]
      @(posedge clock) disable iff (!arst_n)
      (32'(quiet_ff) == RELEASE + 3) |-> !resetOutPin)
      else $error("internal reset held past the fixed delay");

   a_por_holds_reset: assert property ( // see [R5]
      @(posedge clock) disable iff (!arst_n)
      (32'(boot_ff) < RELEASE) |-> resetOutPin)
      else $error("power-on reset released too soon");

   a_out_mirrors_state: assert property ( // see [R6]
      @(posedge clock) disable iff (!arst_n)
      resetOutPin == inReset)
      else $error("reset output differs from internal reset");

   a_pullups_on_reset: assert property ( // see [R7] [R9] [R11]
      @(posedge clock) disable iff (!arst_n)
      resetOutPin ##1 resetOutPin |=>
         resetPullupEn && bootSelPullupEn && extMemPullupEn)
      else $error("a pull-up stayed off through reset");

   a_secure_forces_int: assert property ( // see [R15] [R12]
      @(posedge clock) disable iff (!arst_n)
      (flashSecured || TIE_LOW) && inReset |=> !extMemMode && !mapSelect)
      else $error("external mode taken while secured or tied low");

   a_secure_map_zero: assert property ( // see [R15] [R8]
      @(posedge clock) disable iff (!arst_n)
      !resetOutPin && !securityMode |-> !mapSelect)
      else $error("map select set although flash was secured");

   a_mode_frozen: assert property ( // see [R14]
      @(posedge clock) disable iff (!arst_n)
      !inReset && !$past(inReset) |-> $stable(securityMode))
      else $error("security mode changed outside reset");

   a_clock_legal: assert property ( // see [R13]
      @(posedge clock) disable iff (!arst_n)
      legalClk(clkSrcSel))
      else $error("clock source select holds an unlisted code");

   a_bus_answers: assert property (
      @(posedge clock) disable iff (!arst_n)
      (read || write) && !inReset && !srcActive && waitrequest
         |-> ##[0:2] !waitrequest)
      else $error("bus request not answered in time");

endmodule

`default_nettype wire

/* File: hdl/reset_boot_pkg.sv */
// constants and types shared by the reset and boot-mode capture block
package reset_boot_pkg;

   // -----------------------------------------------------------------
   // reset release timing
   // -----------------------------------------------------------------
   localparam int unsigned RELEASE_CYCLES = 16;  // clocks after last source

   // -----------------------------------------------------------------
   // register byte offsets on the avalon slave
   // -----------------------------------------------------------------
   localparam logic [3:0] OFS_PULLUP = 4'h0;  // pullup_disable_reg
   localparam logic [3:0] OFS_MODE   = 4'h4;  // operating_mode_reg
   localparam logic [3:0] OFS_CLKSEL = 4'h8;  // clock source select
   localparam logic [3:0] OFS_STATUS = 4'hc;  // reset cause and straps

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int unsigned PUD_RESET  = 0;   // reset pin pull-up off
   localparam int unsigned PUD_BOOT   = 1;   // boot_select_pullup_off
   localparam int unsigned PUD_EXTMEM = 2;   // ext memory pull-up off
   localparam int unsigned MODE_MAP   = 0;   // map_select_bit
   localparam int unsigned MODE_SEC   = 1;   // security_mode_bit
   localparam int unsigned MODE_EXTM  = 2;   // captured ext memory mode
   localparam int unsigned ST_POR     = 0;   // power-on reset seen
   localparam int unsigned ST_PIN     = 1;   // reset pin seen
   localparam int unsigned ST_SECURED = 2;   // flash secured, live
   localparam int unsigned ST_BOOTREQ = 3;   // boot select, live

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [2:0]  PUD_RESET_VAL = 3'h0;  // all pull-ups on
   localparam logic [31:0] READ_ZERO     = 32'h0000_0000;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      CLK_RESONATOR = 2'h0,
      CLK_CRYSTAL   = 2'h1,
      CLK_EXTERNAL  = 2'h3
   } clk_src_t;

   // gray order: hold -> count -> run
   typedef enum logic [1:0] {
      SEQ_HOLD  = 2'h0,
      SEQ_COUNT = 2'h1,
      SEQ_RUN   = 2'h3
   } seq_state_t;

endpackage

/* File: test/board_reset_model.sv */
// board reset supervisor model driving the reset pin and test reset
`timescale 1ns/1ps
`default_nettype none

module board_reset_model (
   input  wire logic clock,
   output var  logic resetPinN,
   output var  logic trstN
);
   // -----------------------------------------------------------------
   // reset press
   // -----------------------------------------------------------------
   // both lines rest high, where the pad pull-ups would leave them
   initial begin
      resetPinN = 1'b1;
      trstN     = 1'b1;
   end

   // a full press pulls test reset too; a debug press leaves it off so
   // the debug logic keeps its state across the chip reset
   task automatic press(input int cycles, input bit full);
      @(posedge clock);
      resetPinN <= 1'b0;
      trstN     <= !full;
      repeat (cycles) @(posedge clock);
      resetPinN <= 1'b1;
      trstN     <= 1'b1;
   endtask
endmodule

`default_nettype wire

/* File: test/reset_boot_capture_bench.sv */
// self-checking bench for the reset and boot-mode capture block
`timescale 1ns/1ps
`default_nettype none

module reset_boot_capture_bench import reset_boot_pkg::*;;
   // -----------------------------------------------------------------
   // signals and model state
   // -----------------------------------------------------------------
   localparam int REL = 4;  // short release count keeps the run brief
   logic        clock = 1'b0;
   logic        arst_n, resetPinN, trstN, read, write, waitrequest;
   logic        bootSourceSelect, extMemModeSelect, flashSecured;
   logic [3:0]  address, byteenable;
   logic [31:0] writedata, readdata, q;
   logic        resetOutPin, resetPullupEn, bootSelPullupEn;
   logic        extMemPullupEn, mapSelect, securityMode, extMemMode;
   logic [1:0]  clkSrcSel;
   int          miscompares, nTests, pudM, clkM;
   bit          mapM, secM, extM;

   // 100 ns period
   always #50 clock = ~clock;

   reset_boot_capture #(.RELEASE(REL), .TIE_LOW(1'b0))
   reset_boot_capture_inst (
      .clock(clock), .arst_n(arst_n), .resetPinN(resetPinN),
      .bootSourceSelect(bootSourceSelect),
      .extMemModeSelect(extMemModeSelect), .flashSecured(flashSecured),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest),
      .resetOutPin(resetOutPin), .resetPullupEn(resetPullupEn),
      .bootSelPullupEn(bootSelPullupEn), .extMemPullupEn(extMemPullupEn),
      .mapSelect(mapSelect), .securityMode(securityMode),
      .extMemMode(extMemMode), .clkSrcSel(clkSrcSel));

   board_reset_model board_reset_model_inst (
      .clock(clock), .resetPinN(resetPinN), .trstN(trstN));

   // -----------------------------------------------------------------
   // shared tasks
   // -----------------------------------------------------------------
   task automatic completeRun();
      if (miscompares == 0 && nTests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      nTests++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   // one avalon transfer; the leading edge keeps back-to-back calls from
   // driving a strobe twice in one time step
   task automatic bus(input bit wr, input logic [3:0] a,
                      input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clock);
      read       <= !wr;
      write      <= wr;
      address    <= a;
      writedata  <= d;
      byteenable <= be;
      @(posedge clock);
      while (waitrequest !== 1'b0 && n < 100) begin
         @(posedge clock);
         n++;
      end
      check("bus answer", 32'h1, 32'(n < 100));
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
      // a write lands at this edge and the pad enables one edge later
      if (wr) begin
         repeat (2) @(posedge clock);
      end
   endtask

   task automatic rd(input string what, input logic [3:0] a,
                     input logic [31:0] mask, input logic [31:0] exp);
      bus(1'b0, a, 32'h0, 4'hf);
      check(what, exp, q & mask);
   endtask

   // edges until the chip leaves reset, which must not come early
   task automatic wait_release(input string what);
      int n;
      n = 0;
      while (resetOutPin !== 1'b0 && n < 40) begin
         @(posedge clock);
         n++;
      end
      check(what, 32'h1, 32'(n >= REL && n <= REL + 3));
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic boot_case(input bit b, input bit e, input bit s);
      pudM = $urandom_range(7);
      bus(1'b1, OFS_PULLUP, 32'(pudM), 4'hf);
      check("pull-ups", 32'(~pudM & 7),
            {extMemPullupEn, bootSelPullupEn, resetPullupEn});
      bootSourceSelect <= b;
      extMemModeSelect <= e;
      flashSecured     <= s;
      board_reset_model_inst.press(3, b);
      check("reset out in reset", 32'h1, resetOutPin);
      wait_release("release after pin");
      secM = !s;
      mapM = b & !s;
      extM = e & b & !s;
      bootSourceSelect <= !b;
      flashSecured     <= !s;
      repeat (2) @(posedge clock);
      check("mode bits", {extM, secM, mapM},
            {extMemMode, securityMode, mapSelect});
      rd("mode reg", OFS_MODE, 32'h7, {extM, secM, mapM});
      // the press sets the pin cause; power-on cause was cleared before
      rd("status live", OFS_STATUS, 32'hf, {!b, !s, 2'h2});
      bus(1'b1, OFS_STATUS, 32'h2, 4'hf);
      rd("pin cause cleared", OFS_STATUS, 32'h3, 32'h0);
      rd("pull-up after reset", OFS_PULLUP, 32'hffff_ffff, 32'h0);
      bus(1'b1, OFS_MODE, 32'(!mapM), 4'hf);
      if (secM) begin
         mapM = !mapM;
      end
      check("map write", mapM, mapSelect);
   endtask

   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      int c;
      void'($urandom(57589));
      arst_n = 1'b0;
      {bootSourceSelect, extMemModeSelect, flashSecured} = 3'h0;
      {read, write, address, byteenable, writedata} = '0;
      miscompares = 0;
      nTests = 0;
      repeat (2) @(posedge clock);
      check("reset out at power-on", 32'h1, resetOutPin);
      check("pull-ups at power-on", 32'h7,
            {extMemPullupEn, bootSelPullupEn, resetPullupEn});
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      wait_release("release after power-on");
      rd("status", OFS_STATUS, 32'hd, 32'h1);
      bus(1'b1, OFS_STATUS, 32'h1, 4'hf);
      rd("power-on cleared", OFS_STATUS, 32'h1, 32'h0);
      rd("pull-up reg", OFS_PULLUP, 32'hffff_ffff, 32'h0);
      rd("unmapped", 4'h2, 32'hffff_ffff, 32'h0);
      pudM = $urandom_range(7);
      bus(1'b1, OFS_PULLUP, 32'(pudM), 4'hf);
      bus(1'b1, OFS_PULLUP, 32'(~pudM), 4'he);
      rd("lane gated", OFS_PULLUP, 32'h7, 32'(pudM));
      // codes 0..3; the unused code 2 must leave the source alone
      clkM = 0;
      for (c = 0; c < 4; c++) begin
         bus(1'b1, OFS_CLKSEL, ($urandom() & 32'hffff_fffc) | c, 4'hf);
         if (c != 2) begin
            clkM = c;
         end
         check("clock source", 32'(clkM), clkSrcSel);
         rd("clock reg", OFS_CLKSEL, 32'h3, 32'(clkM));
      end
      for (c = 0; c < 8; c++) begin
         boot_case(c[0], c[1], c[2]);
      end
      // a second press inside the count must restart it
      board_reset_model_inst.press(3, 1'b1);
      repeat (2) @(posedge clock);
      board_reset_model_inst.press(2, 1'b0);
      wait_release("restarted release");
      completeRun();
   end

   // cut a hang short
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      completeRun();
   end
endmodule

`default_nettype wire
